//--- hw/motor_setpoint_cfg.svh
// Named constants for the motor setpoint register bank: command codes, field layout, scaling.
// Assumes inclusion by bare name from any design file; holds definitions only.
`ifndef MOTOR_SETPOINT_CFG_SVH
`define MOTOR_SETPOINT_CFG_SVH

// Write command for the base speed setpoint; the other setpoints follow at +1, +2, +3.
`define CMD_WR_BASE      8'h00
// Read command for the base speed setpoint; reads of the others follow at +1, +2, +3.
`define CMD_RD_BASE      8'h40
// Bit of a command byte that marks a two-byte read request.
`define CMD_RD_BIT       6
// Lock, unlock and save commands, carried in ordinary five-byte write frames.
`define CMD_LOCK         8'h20
`define CMD_UNLOCK       8'h21
`define CMD_SAVE         8'h22
// Bit that marks an address byte on the link.
`define ADDR_FLAG_BIT    7
// Mask applied to the check byte sum.
`define CHK_MASK         8'h7F
// Flag ORed into the acknowledge byte on a check error.
`define ACK_ERR          8'h80
// Flag ORed into the acknowledge byte on success.
`define ACK_OK           8'h00
// Number of setpoints held by the bank.
`define NUM_SP           4
// Index of each setpoint inside the bank.
`define SP_SPEED         0
`define SP_DRIVE_AMP     1
`define SP_BRAKE_AMP     2
`define SP_RISE_RAMP     3
// Full-scale setpoint code and the duty, in hundredths of a percent, that it maps to.
`define SP_FULL          26'h000_0FFF
`define DUTY_MAX_CENTI   26'h000_25E4
// Reset value of every setpoint and of the duty outputs.
`define SP_RESET         12'h000
`define DUTY_RESET       14'h0000
// Bytes in a read reply.
`define RD_REPLY_BYTES   2'h3
// Bytes in a write acknowledge.
`define ACK_BYTES        2'h1

`endif

//--- hw/motor_setpoint_pkg.sv
// Types shared by the motor setpoint register bank and its setpoint slots.
// Assumes nothing beyond a SystemVerilog compiler.
package motor_setpoint_pkg;

  // A twelve-bit unsigned setpoint code.
  typedef logic [11:0] setpoint_t;

  // Duty in hundredths of a percent, 0 to 9700.
  typedef logic [13:0] duty_t;

  // Serial frame parser state, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD  = 5'b00010,
    ST_D1   = 5'b00100,
    ST_D2   = 5'b01000,
    ST_CHK  = 5'b10000
  } frame_state_t;

endpackage : motor_setpoint_pkg

//--- hw/setpoint_slot.sv
// One setpoint: tracks its analog source, takes serial overrides, and honours the lock.
// Assumes a synchronised active-low reset and digitised inputs synchronous to the clock.
module setpoint_slot (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire motor_setpoint_pkg::setpoint_t adc,
  input  wire motor_setpoint_pkg::setpoint_t src,
  input  wire logic                          wr,
  input  wire motor_setpoint_pkg::setpoint_t wr_data,
  input  wire logic                          lock,
  output motor_setpoint_pkg::setpoint_t      value
);
  import motor_setpoint_pkg::*;
  `include "motor_setpoint_cfg.svh"

  setpoint_t value_q;    // Held setpoint.
  setpoint_t value_d;    // Next setpoint.
  setpoint_t ref_q;      // Analog reading seen at the last write, reload or locked cycle.
  setpoint_t ref_d;      // Next reference reading.
  logic      over_q;     // A serial write is in force.
  logic      over_d;     // Next override flag.

  // The reference is refreshed while locked, so only movement after unlock reloads.
  wire adc_moved = (adc != ref_q);

  // Next-state logic; a write wins over both lock and analog movement.
  always_comb begin
    value_d = value_q;
    ref_d   = ref_q;
    over_d  = over_q;
    if (wr) begin
      value_d = wr_data;
      ref_d   = adc;
      over_d  = 1'b1;
    end else if (lock) begin
      ref_d   = adc;
    end else if (adc_moved) begin
      value_d = src;
      ref_d   = adc;
      over_d  = 1'b0;
    end else if (!over_q) begin
      value_d = src;
    end
  end

  // Nothing survives a restart; the slot falls back to tracking its source.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= `SP_RESET;
      ref_q   <= `SP_RESET;
      over_q  <= 1'b0;
    end else begin
      value_q <= value_d;
      ref_q   <= ref_d;
      over_q  <= over_d;
    end
  end

  assign value = value_q;

  // A moved input replaces an unlocked setpoint in the next cycle.
  // The sampled reset keeps the release edge, where the slot still sat in reset, out of it.
  reload_on_move_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && !wr && !lock && adc_moved) |=> (value_q == $past(src)))
    else $error("setpoint did not reload after analog input moved");

  // An override stands while the input keeps its reading.
  override_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
    (over_q && !wr && !adc_moved) |=> $stable(value_q))
    else $error("overridden setpoint changed without input movement");

endmodule : setpoint_slot

//--- hw/motor_setpoint_register_bank.sv
// Setpoint register bank of a brushed motor PWM controller, reached over an addressed byte link.
// Assumes bytes already deserialised by a UART and digitised analog inputs on core_clk.
// What this block does
// - Speed setpoint tracks ramped speed input by default.
// - Written speed holds while input reading unchanged.
// - Input movement replaces an overridden speed setpoint.
// - Lock freezes speed setpoint against input changes.
// - Setpoint 4095 gives 97 percent, 0 gives 0.
// - Speed is base duty; limiters may lower it.
// - Restart discards written values; flash saves survive.
// - Drive current limit: write 0x01, read 0x41.
// - Drive current limit tracks its pot by default.
// - Limit writes override until their input moves.
// - Lock keeps limits against analog input changes.
// - Braking current limit: write 0x02, read 0x42.
// - Braking limit tracks its pot by default.
// - Rise ramp value steers acceleration, tracks pot.
// - Setpoints are twelve bits, 0 to 4095.
// - Address bytes MSB one, all others zero.
// - Check byte is masked sum of three.
// - Write acknowledged by address, 0x80 flag on error.
// - Read request two bytes; reply three bytes.
module motor_setpoint_register_bank
  import motor_setpoint_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h00   // Link address of this controller.
)
(
  input  wire logic       core_clk,        // System clock, 20 MHz.
  input  wire logic       reset_n,         // Asynchronous active-low reset.
  input  wire logic [7:0] rx_byte,         // Received link byte.
  input  wire logic       rx_valid,        // Received byte is present.
  output logic            rx_ready,        // Bank can take a byte.
  output logic      [7:0] tx_byte,         // Byte to send.
  output logic            tx_valid,        // Byte to send is present.
  input  wire logic       tx_ready,        // Transmitter takes the byte.
  input  wire setpoint_t  speed_adc,       // Digitised speed input.
  input  wire setpoint_t  speed_ramped,    // Speed input after the ramp stage.
  input  wire setpoint_t  drive_amp_adc,   // Digitised drive current limit pot.
  input  wire setpoint_t  brake_amp_adc,   // Digitised braking current limit pot.
  input  wire setpoint_t  rise_ramp_adc,   // Digitised ramp pot.
  input  wire duty_t      duty_cap,        // Ceiling from current limit and braking logic.
  output setpoint_t       base_duty_setpoint,
  output setpoint_t       drive_amp_ceiling_setpoint,
  output setpoint_t       braking_amp_ceiling_setpoint,
  output setpoint_t       rise_ramp_time_setpoint,
  output duty_t           base_duty,       // Base duty in hundredths of a percent.
  output duty_t           applied_duty,    // Base duty after the external ceiling.
  output logic            lock_active,     // Lock command in force.
  output logic            save_strobe      // One-cycle request to store setpoints in flash.
);
  import motor_setpoint_pkg::*;
  `include "motor_setpoint_cfg.svh"

  // Masked sum used for both incoming checks and outgoing replies.
  function automatic logic [7:0] check_of(input logic [7:0] c, input logic [7:0] a,
                                          input logic [7:0] b);
    logic [7:0] s;
    s = c + a + b;
    return s & `CHK_MASK;
  endfunction

  // Linear map from a setpoint code to hundredths of a percent of duty.
  function automatic duty_t duty_of(input setpoint_t sp);
    logic [25:0] p;
    p = 26'(sp) * `DUTY_MAX_CENTI;
    return 14'(p / `SP_FULL);
  endfunction

  // Reset release through two flip-flops.
  logic rst_meta_q;     // First stage, read only by the second.
  logic rst_n_q;        // Synchronised reset used everywhere else.

  // The asynchronous assert keeps outputs quiet at once; release waits two edges.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  frame_state_t state_q;      // Frame parser state.
  frame_state_t state_d;      // Next parser state.
  logic [7:0]   cmd_q;        // Command byte of the frame.
  logic [7:0]   d1_q;         // First data byte.
  logic [7:0]   d2_q;         // Second data byte.
  logic [23:0]  tx_sh_q;      // Reply bytes, oldest in the top lane.
  logic [1:0]   tx_cnt_q;     // Reply bytes still to send.
  logic         lock_q;       // Lock in force.
  logic         save_q;       // Save request pulse.
  duty_t        base_duty_q;  // Registered base duty.
  duty_t        applied_q;    // Registered applied duty.
  setpoint_t    sp_value [`NUM_SP];  // Held setpoints.
  setpoint_t    sp_adc   [`NUM_SP];  // Inputs watched for movement.
  setpoint_t    sp_src   [`NUM_SP];  // Values loaded while tracking.

  // Byte acceptance stalls while a reply is draining, so replies never overlap.
  assign rx_ready = (tx_cnt_q == 2'h0);
  wire rx_take    = rx_valid && rx_ready;
  wire is_addr    = rx_byte[`ADDR_FLAG_BIT];
  wire addr_hit   = is_addr && (rx_byte[6:0] == DEV_ADDR);
  wire data_take  = rx_take && !is_addr;
  wire is_read    = rx_byte[`CMD_RD_BIT];
  wire rd_req     = data_take && (state_q == ST_CMD) && is_read;
  wire frame_end  = data_take && (state_q == ST_CHK);
  wire chk_ok     = (rx_byte == check_of(cmd_q, d1_q, d2_q));
  wire wr_commit  = frame_end && chk_ok;
  wire [13:0] wr_word = {d1_q[6:0], d2_q[6:0]};
  wire setpoint_t wr_data = wr_word[11:0];

  // Reads beyond the bank return zero data with a valid check byte.
  wire [7:0]  rd_off  = rx_byte - `CMD_RD_BASE;
  wire        rd_hit  = (rd_off < 8'(`NUM_SP));
  wire setpoint_t rd_val = rd_hit ? sp_value[rd_off[1:0]] : `SP_RESET;
  wire [7:0]  rd_b1   = {3'h0, rd_val[11:7]};
  wire [7:0]  rd_b2   = {1'h0, rd_val[6:0]};
  wire [7:0]  ack     = {1'b0, DEV_ADDR} | (chk_ok ? `ACK_OK : `ACK_ERR);

  // Parser: an address byte restarts the frame anywhere; a foreign one sends us idle.
  always_comb begin
    state_d = state_q;
    if (rx_take) begin
      if (is_addr) begin
        state_d = addr_hit ? ST_CMD : ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: state_d = ST_IDLE;
          ST_CMD:  state_d = is_read ? ST_IDLE : ST_D1;
          ST_D1:   state_d = ST_D2;
          ST_D2:   state_d = ST_CHK;
          ST_CHK:  state_d = ST_IDLE;
          default: state_d = ST_IDLE;
        endcase
      end
    end
  end

  // Parser state and frame byte capture.
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      cmd_q   <= 8'h00;
      d1_q    <= 8'h00;
      d2_q    <= 8'h00;
    end else begin
      state_q <= state_d;
      if (data_take && (state_q == ST_CMD)) cmd_q <= rx_byte;
      if (data_take && (state_q == ST_D1))  d1_q  <= rx_byte;
      if (data_take && (state_q == ST_D2))  d2_q  <= rx_byte;
    end
  end

  // Reply shifter: one acknowledge after a write frame, three bytes after a read.
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_sh_q  <= 24'h00_0000;
      tx_cnt_q <= 2'h0;
    end else if (rd_req) begin
      tx_sh_q  <= {rd_b1, rd_b2, check_of(rx_byte, rd_b1, rd_b2)};
      tx_cnt_q <= `RD_REPLY_BYTES;
    end else if (frame_end) begin
      tx_sh_q  <= {ack, 16'h0000};
      tx_cnt_q <= `ACK_BYTES;
    end else if (tx_valid && tx_ready) begin
      tx_sh_q  <= {tx_sh_q[15:0], 8'h00};
      tx_cnt_q <= tx_cnt_q - 2'h1;
    end
  end

  assign tx_valid = (tx_cnt_q != 2'h0);
  assign tx_byte  = tx_sh_q[23:16];

  // Lock, unlock and save act only on frames whose check byte matched.
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lock_q <= 1'b0;
      save_q <= 1'b0;
    end else begin
      if (wr_commit && (cmd_q == `CMD_LOCK))   lock_q <= 1'b1;
      if (wr_commit && (cmd_q == `CMD_UNLOCK)) lock_q <= 1'b0;
      save_q <= wr_commit && (cmd_q == `CMD_SAVE);
    end
  end

  assign lock_active = lock_q;
  assign save_strobe = save_q;

  // Source wiring: speed loads the ramped value but watches the raw reading for movement.
  assign sp_adc[`SP_SPEED]     = speed_adc;
  assign sp_src[`SP_SPEED]     = speed_ramped;
  assign sp_adc[`SP_DRIVE_AMP] = drive_amp_adc;
  assign sp_src[`SP_DRIVE_AMP] = drive_amp_adc;
  assign sp_adc[`SP_BRAKE_AMP] = brake_amp_adc;
  assign sp_src[`SP_BRAKE_AMP] = brake_amp_adc;
  assign sp_adc[`SP_RISE_RAMP] = rise_ramp_adc;
  assign sp_src[`SP_RISE_RAMP] = rise_ramp_adc;

  // One slot per setpoint; the write code selects the slot.
  for (genvar i = 0; i < `NUM_SP; i++) begin : g_slot
    wire wr_here = wr_commit && (cmd_q == (`CMD_WR_BASE + 8'(i)));
    setpoint_slot u_slot (
      .clk     (core_clk),
      .rst_n   (rst_n_q),
      .adc     (sp_adc[i]),
      .src     (sp_src[i]),
      .wr      (wr_here),
      .wr_data (wr_data),
      .lock    (lock_q),
      .value   (sp_value[i])
    );
  end

  assign base_duty_setpoint           = sp_value[`SP_SPEED];
  assign drive_amp_ceiling_setpoint   = sp_value[`SP_DRIVE_AMP];
  assign braking_amp_ceiling_setpoint = sp_value[`SP_BRAKE_AMP];
  assign rise_ramp_time_setpoint      = sp_value[`SP_RISE_RAMP];

  // Duty scaling; the limiter ceiling can only lower the base value.
  wire duty_t base_now = duty_of(sp_value[`SP_SPEED]);
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      base_duty_q <= `DUTY_RESET;
      applied_q   <= `DUTY_RESET;
    end else begin
      base_duty_q <= base_now;
      applied_q   <= (duty_cap < base_now) ? duty_cap : base_now;
    end
  end

  assign base_duty    = base_duty_q;
  assign applied_duty = applied_q;

  // The checks below all run on core_clk and sleep while the synchronised reset is low.
  // Several guard decode paths that the link tests only reach through the reply bytes.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_q);

  // The last data byte of a write frame followed by its check byte.
  sequence write_tail_s;
    (data_take && state_q == ST_D2) ##[1:50] frame_end;
  endsequence

  ack_good_a: assert property (frame_end && chk_ok |=> tx_valid && tx_byte == {1'b0, DEV_ADDR})
    else $error("good write frame not acknowledged with plain address");

  ack_bad_a: assert property (frame_end && !chk_ok |=> tx_valid && tx_byte == {1'b1, DEV_ADDR})
    else $error("bad check byte not flagged in acknowledge");

  write_acked_a: assert property (write_tail_s |=> tx_valid && tx_cnt_q == 2'h1)
    else $error("write frame did not produce exactly one reply byte");

  read_check_a: assert property (rd_req |=> tx_cnt_q == 2'h3 &&
      tx_sh_q[7:0] == check_of($past(rx_byte), tx_sh_q[23:16], tx_sh_q[15:8]))
    else $error("read reply check byte wrong");

  read_bits_a: assert property (rd_req |=> !tx_sh_q[23] && !tx_sh_q[15] && !tx_sh_q[7]
      && tx_sh_q[22:21] == 2'h0)
    else $error("read reply byte has top bit or reserved bits set");

  drive_read_a: assert property (rd_req && rx_byte == 8'h41 |=>
      {tx_sh_q[20:16], tx_sh_q[14:8]} == $past(sp_value[`SP_DRIVE_AMP]))
    else $error("drive current limit read returned wrong value");

  brake_write_a: assert property (wr_commit && cmd_q == 8'h02 |=>
      braking_amp_ceiling_setpoint == $past(wr_data))
    else $error("braking current limit write not taken");

  lock_hold_a: assert property (lock_q && !wr_commit ##1 lock_q |->
      $stable(base_duty_setpoint) && $stable(rise_ramp_time_setpoint))
    else $error("locked setpoint changed without a write");

  duty_scale_a: assert property (base_duty_q == duty_of($past(base_duty_setpoint)))
    else $error("base duty not scaled from speed setpoint");

  duty_cap_a: assert property (applied_q <= base_duty_q && applied_q <= $past(duty_cap))
    else $error("applied duty above base or ceiling");

  // An address byte for another controller parks the parser until our address returns.
  foreign_addr_a: assert property (rx_take && is_addr && !addr_hit |=>
      state_q == ST_IDLE)
    else $error("foreign address byte did not park the parser");

  // A stray data byte while idle is dropped without any reply.
  stray_byte_a: assert property (rx_take && !is_addr && state_q == ST_IDLE |=>
      state_q == ST_IDLE && !tx_valid)
    else $error("stray data byte changed the parser or started a reply");

  // A frame with a bad check byte must leave lock and save untouched.
  bad_frame_quiet_a: assert property (frame_end && !chk_ok |=>
      $stable(lock_q) && !save_q)
    else $error("bad write frame changed lock or save");

  // The speed setpoint reads back in the two data bytes of the reply.
  speed_read_a: assert property (rd_req && rx_byte == `CMD_RD_BASE |=>
      {tx_sh_q[20:16], tx_sh_q[14:8]} == $past(base_duty_setpoint))
    else $error("speed setpoint read returned wrong value");

  // A good unlock frame releases the setpoints to their inputs again.
  unlock_clears_a: assert property (wr_commit && cmd_q == `CMD_UNLOCK |=> !lock_q)
    else $error("unlock frame did not clear the lock");

  // A save request lasts one cycle, so the flash side sees one request per frame.
  save_pulse_a: assert property (save_q |=> !save_q)
    else $error("save request longer than one cycle");

endmodule : motor_setpoint_register_bank

//--- bench/setpoint_link_host.sv
// Serial master model for the setpoint bank: frames commands and collects replies.
// Assumes the bank's byte-level link ports and a free-running core_clk.
module setpoint_link_host (
  input  wire logic       core_clk,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle at time zero; nothing is offered and no reply is taken.
  initial begin
    rx_byte  = 8'h55;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end

  // Offers one byte and holds it until an edge sees the bank ready.
  // The released line shows the inverse so a stale byte never looks valid.
  task automatic put_byte(input logic [7:0] b);
    @(posedge core_clk);
    rx_byte  <= b;
    rx_valid <= 1'b1;
    do @(posedge core_clk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_byte  <= ~b;
  endtask

  // Takes one reply byte after a random stall of up to three cycles.
  task automatic get_byte(output logic [7:0] b);
    int stall;
    stall = $urandom_range(3);
    do @(posedge core_clk); while (tx_valid !== 1'b1);
    repeat (stall) @(posedge core_clk);
    tx_ready <= 1'b1;
    @(posedge core_clk);
    b = tx_byte;
    tx_ready <= 1'b0;
  endtask

  // Five-byte write frame; a set bad flag spoils the check byte on purpose.
  task automatic wr_frame(input logic [6:0] a, input logic [7:0] cmd, input logic [11:0] v,
                          input bit bad, output logic [7:0] ack);
    logic [7:0] d1, d2, chk;
    d1  = {3'b000, v[11:7]};
    d2  = {1'b0, v[6:0]};
    chk = ((cmd + d1 + d2) & 8'h7F) ^ {7'h00, bad};
    put_byte({1'b1, a});
    put_byte(cmd);
    put_byte(d1);
    put_byte(d2);
    put_byte(chk);
    get_byte(ack);
  endtask

  // Two-byte read request followed by the three reply bytes.
  task automatic rd_frame(input logic [6:0] a, input logic [7:0] cmd, output logic [7:0] d1,
                          output logic [7:0] d2, output logic [7:0] chk);
    put_byte({1'b1, a});
    put_byte(cmd);
    get_byte(d1);
    get_byte(d2);
    get_byte(chk);
  endtask
endmodule // setpoint_link_host

//--- bench/motor_setpoint_register_bank_bench.sv
// Self-checking bench for the setpoint bank, with an integer model of the setpoints.
// Assumes the link host model and the design package are compiled before it.
module motor_setpoint_register_bank_bench import motor_setpoint_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [6:0] ADDR = 7'h35;    // Non-zero so that address matching is exercised.
  logic       core_clk = 1'b0;            // System clock.
  logic       reset_n;                    // Reset; its fall at time zero resets at once.
  logic [7:0] rx_byte, tx_byte;           // Link bytes.
  logic [7:0] rb1, rb2, rb3;              // Reply bytes of an unmapped read.
  logic       rx_valid, rx_ready, tx_valid, tx_ready;
  setpoint_t  adc[4];                     // Analog readings, slot order of the bank.
  setpoint_t  ramped;                     // Speed input after the ramp stage.
  duty_t      duty_cap;                   // External duty ceiling.
  setpoint_t  sp_o[4];                    // Held setpoints seen at the outputs.
  duty_t      base_duty, applied_duty;
  logic       lock_active, save_strobe;
  int         m_val[4], m_ref[4], m_ov[4];  // Model value, reference reading, override flag.
  int         m_lock, m_saves, save_cnt, err_count, compares;

  setpoint_link_host host (.core_clk(core_clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));

  motor_setpoint_register_bank #(.DEV_ADDR(ADDR)) uut (.core_clk(core_clk), .reset_n(reset_n),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .speed_adc(adc[0]), .speed_ramped(ramped),
    .drive_amp_adc(adc[1]), .brake_amp_adc(adc[2]), .rise_ramp_adc(adc[3]),
    .duty_cap(duty_cap), .base_duty_setpoint(sp_o[0]), .drive_amp_ceiling_setpoint(sp_o[1]),
    .braking_amp_ceiling_setpoint(sp_o[2]), .rise_ramp_time_setpoint(sp_o[3]),
    .base_duty(base_duty), .applied_duty(applied_duty), .lock_active(lock_active),
    .save_strobe(save_strobe));

  // Clock at 20 MHz.
  always #25 core_clk = ~core_clk;

  // Counts save pulses; a pulse longer than one cycle shows up as an extra count.
  always @(posedge core_clk) if (save_strobe === 1'b1) save_cnt++;

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Model of tracking: a moved reading ends an override unless locked.
  task automatic model_step();
    for (int i = 0; i < 4; i++) begin
      if (m_lock == 0 && adc[i] != m_ref[i]) m_ov[i] = 0;
      m_ref[i] = adc[i];
      if (m_lock == 0 && m_ov[i] == 0) m_val[i] = (i == 0) ? ramped : adc[i];
    end
  endtask

  // Moves inputs on an edge, lets the bank settle, then steps the model.
  task automatic drive_in(input bit move_adc, input bit move_src);
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) if (move_adc) adc[i] <= 12'($urandom_range(4095));
    if (move_src) ramped <= 12'($urandom_range(4095));
    duty_cap <= 14'($urandom_range(16383));
    repeat (4) @(posedge core_clk);
    model_step();
  endtask

  // Pulses reset; the model forgets every write and override.
  task automatic do_reset();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    m_lock = 0;
    m_ov   = '{default: 0};
    m_ref  = '{default: -1};
    model_step();
  endtask

  // Checks every setpoint, both duties and the lock flag against the model.
  task automatic check_all();
    int bd;
    bd = m_val[0] * 9700 / 4095;
    for (int i = 0; i < 4; i++) check(16'(sp_o[i]), 16'(m_val[i]));
    check(16'(base_duty), 16'(bd));
    check(16'(applied_duty), 16'((duty_cap < bd) ? duty_cap : bd));
    check(16'(lock_active), 16'(m_lock));
  endtask

  // Write frame with acknowledge check; the model follows good frames only.
  task automatic wr(input logic [7:0] cmd, input int v, input bit bad);
    logic [7:0] ack;
    host.wr_frame(ADDR, cmd, v[11:0], bad, ack);
    check(16'(ack), 16'({bad, ADDR}));
    if (!bad && cmd < 8'h04) begin
      m_val[cmd] = v;
      m_ov[cmd]  = 1;
      m_ref[cmd] = adc[cmd];
    end
    if (!bad && cmd == 8'h20) m_lock = 1;
    if (!bad && cmd == 8'h21) m_lock = 0;
    if (!bad && cmd == 8'h22) m_saves++;
    repeat (2) @(posedge core_clk);
  endtask

  // Read frame; expected bytes are built from the model value.
  task automatic rd(input int i);
    logic [7:0] d1, d2, chk, cmd, e1, e2;
    cmd = 8'h40 + 8'(i);
    e1  = {3'b000, 5'(m_val[i] >> 7)};
    e2  = {1'b0, 7'(m_val[i])};
    host.rd_frame(ADDR, cmd, d1, d2, chk);
    check({d1, d2}, {e1, e2});
    check(16'(chk), 16'((cmd + e1 + e2) & 8'h7F));
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    finish_test();
  end

  // Main sequence.
  initial begin
    reset_n  = 1'b0;
    adc      = '{default: 12'h000};
    ramped   = 12'h000;
    duty_cap = 14'h0000;
    void'($urandom(59));
    do_reset();
    drive_in(1, 1);
    check_all();
    drive_in(1, 1);
    check_all();
    $display("test tracking done");
    for (int i = 0; i < 4; i++) begin
      wr(8'(i), $urandom_range(4095), 0);
      rd(i);
      check_all();
    end
    wr(8'h00, 4095, 0);
    check_all();
    wr(8'h00, 0, 0);
    check_all();
    $display("test write readback done");
    for (int i = 0; i < 4; i++) wr(8'(i), $urandom_range(4095), 0);
    drive_in(0, 1);
    check_all();
    drive_in(1, 0);
    check_all();
    $display("test override done");
    wr(8'h01, $urandom_range(4095), 1);
    host.put_byte(8'h05);
    host.put_byte({1'b1, ADDR + 7'h01});
    host.put_byte(8'h01);
    host.put_byte(8'h02);
    host.put_byte(8'h23);
    host.put_byte(8'h26);
    rd(1);
    wr(8'h10, $urandom_range(4095), 0);
    host.rd_frame(ADDR, 8'h44, rb1, rb2, rb3);
    check({rb1, rb2}, 16'h0000);
    check(16'(rb3), 16'h0044);
    check_all();
    $display("test refused frames done");
    wr(8'h02, $urandom_range(4095), 0);
    wr(8'h20, 0, 0);
    drive_in(1, 1);
    check_all();
    wr(8'h03, $urandom_range(4095), 0);
    check_all();
    wr(8'h21, 0, 0);
    drive_in(1, 1);
    check_all();
    wr(8'h22, 0, 0);
    check(16'(save_cnt), 16'(m_saves));
    $display("test lock and save done");
    wr(8'h00, $urandom_range(4095), 0);
    wr(8'h01, $urandom_range(4095), 0);
    do_reset();
    check_all();
    $display("test restart done");
    finish_test();
  end
endmodule // motor_setpoint_register_bank_bench
